// ==== rtl/slr_pkg.sv ====
// package with register map, field layout and carrier types of the literal/adjust bank
// What this block does
// - control step command with literal option copies all 16 literal bits to channel select.
// - while enable and run are both 1, literal and adjust ignore software writes.
// - add step command adds adjust value to timer, counter, step delay limit or literal.
// - literal register is one 16-bit read/write field, zero after power-on reset.
// - adjust register is one 16-bit addend, software access while sequencer not running.
// - every adjust bit is read/write and clears to zero on power-on reset.
package slr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SLR_DW = 16;
  localparam int SLR_AW = 8;

  // ----------------------------------------------------------------
  // register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [SLR_AW-1:0] SLR_LIT_OFS = 8'h00;
  localparam logic [SLR_AW-1:0] SLR_ADJ_OFS = 8'h04;
  localparam logic [SLR_AW-1:0] SLR_CTRL_OFS = 8'h08;
  localparam logic [SLR_AW-1:0] SLR_STAT_OFS = 8'h0C;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [SLR_DW-1:0] SLR_LIT_RST = 16'h0000;
  localparam logic [SLR_DW-1:0] SLR_ADJ_RST = 16'h0000;
  localparam logic [SLR_DW-1:0] SLR_CHAN_RST = 16'h0000;
  localparam int SLR_CTRL_EN_BIT = 0;
  localparam int SLR_CTRL_RUN_BIT = 1;
  localparam int SLR_STAT_LOCK_BIT = 0;
  localparam int SLR_STAT_TGT_LSB = 1;

  // ----------------------------------------------------------------
  // add step targets
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SLR_TGT_TIMER = 2'h0,
    SLR_TGT_COUNTER = 2'h1,
    SLR_TGT_DELAY = 2'h2,
    SLR_TGT_LITERAL = 2'h3
  } slr_target_t;

  // step command from the sequencer engine, one-cycle pulses
  typedef struct packed {
    logic ctrlLiteral;
    logic addStep;
    slr_target_t target;
  } slr_cmd_t;

  // current limit values owned outside this bank
  typedef struct packed {
    logic [SLR_DW-1:0] timerLimit;
    logic [SLR_DW-1:0] counterLimit;
    logic [SLR_DW-1:0] delayLimit;
  } slr_limits_t;

  // write-back of a sum into an outside limit register
  typedef struct packed {
    logic timerWr;
    logic counterWr;
    logic delayWr;
    logic [SLR_DW-1:0] data;
  } slr_lim_wr_t;

endpackage

// ==== rtl/slr_ahb_if.sv ====
// ahb-lite slave front end: address phase capture, zero wait states, always okay
`timescale 1ns/1ps
module slr_ahb_if
  import slr_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready out
  output logic hresp, // response, always okay
  output logic busWr, // data-phase write strobe
  output logic busRd, // data-phase read valid
  output logic [SLR_AW-1:0] busAddr // data-phase byte address
);

  logic phaseValid_reg;
  logic phaseWrite_reg;
  logic [SLR_AW-1:0] phaseAddr_reg;
  wire logic addrTaken;

  // ----------------------------------------------------------------
  // address phase accepted on nonseq or seq with the bus ready
  // ----------------------------------------------------------------
  assign addrTaken = hsel & htrans[1] & hready;

  // hold address-phase controls for the following data phase
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phaseValid_reg <= 1'b0;
      phaseWrite_reg <= 1'b0;
      phaseAddr_reg <= '0;
    end else if (hready) begin
      phaseValid_reg <= addrTaken;
      phaseWrite_reg <= hwrite;
      phaseAddr_reg <= haddr[SLR_AW-1:0];
    end
  end

  // never stalls, so every data phase lasts one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busWr = phaseValid_reg & phaseWrite_reg;
  assign busRd = phaseValid_reg & ~phaseWrite_reg;
  assign busAddr = phaseAddr_reg;

endmodule

// ==== rtl/slr_add_unit.sv ====
// adder of the add step command: picks the target operand and forms the 16-bit sum
`timescale 1ns/1ps
module slr_add_unit
  import slr_pkg::*;
#(
  parameter int DW = SLR_DW
)
(
  input slr_target_t target, // selected target
  input wire logic [DW-1:0] timerLimit, // timer limit now
  input wire logic [DW-1:0] counterLimit, // counter limit now
  input wire logic [DW-1:0] delayLimit, // step delay limit now
  input wire logic [DW-1:0] literalVal, // literal now
  input wire logic [DW-1:0] addend, // adjust value
  output logic [DW-1:0] sum // wrapped sum
);

  logic [DW-1:0] operand;

  // operand selection by target code
  always_comb begin
    case (target)
      SLR_TGT_TIMER: operand = timerLimit;
      SLR_TGT_COUNTER: operand = counterLimit;
      SLR_TGT_DELAY: operand = delayLimit;
      SLR_TGT_LITERAL: operand = literalVal;
      default: operand = '0;
    endcase
  end

  // carry out of the top bit is discarded on purpose
  assign sum = DW'(operand + addend);

endmodule

// ==== rtl/slr_regs.sv ====
// literal and adjust register bank of the step sequencer, with ahb-lite access
`timescale 1ns/1ps
module slr_regs
  import slr_pkg::*;
#(
  parameter int DW = SLR_DW
)
(
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic rstn, // async power-on reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb byte address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb ready in
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb ready out
  output logic hresp, // ahb response
  input slr_cmd_t stepCmd, // step command pulses from engine
  input slr_limits_t limits, // outside limit values
  output slr_lim_wr_t limWrite, // sum write-back to limits
  output logic [DW-1:0] converterChannelSelect, // channel select value
  output logic chanLoad, // pulse when channel select reloads
  output logic sequencerEnable, // enable control bit
  output logic sequencerRun // run control bit
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [DW-1:0] stepLiteralValue_reg;
  logic [DW-1:0] stepLiteralValue_next;
  logic [DW-1:0] stepAdjustValue_reg;
  logic [DW-1:0] stepAdjustValue_next;
  logic [DW-1:0] chanSel_reg;
  logic chanLoad_reg;
  logic enable_reg;
  logic run_reg;
  slr_target_t lastTarget_reg;
  slr_lim_wr_t limWrite_reg;
  slr_lim_wr_t limWrite_next;
  logic [31:0] readMux;

  wire logic busWr;
  wire logic busRd;
  wire logic [SLR_AW-1:0] busAddr;
  wire logic [DW-1:0] addSum;
  wire logic locked;
  wire logic selLit;
  wire logic selAdj;
  wire logic selCtrl;
  wire logic selStat;
  wire logic swWrLit;
  wire logic swWrAdj;
  wire logic swWrCtrl;
  wire logic hwAddLit;
  wire logic hwAddOut;

  // ----------------------------------------------------------------
  // bus front end and adder
  // ----------------------------------------------------------------
  slr_ahb_if u_ahb (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .busWr(busWr),
    .busRd(busRd),
    .busAddr(busAddr)
  );

  slr_add_unit #(
    .DW(DW)
  ) u_add (
    .target(stepCmd.target),
    .timerLimit(limits.timerLimit),
    .counterLimit(limits.counterLimit),
    .delayLimit(limits.delayLimit),
    .literalVal(stepLiteralValue_reg),
    .addend(stepAdjustValue_reg),
    .sum(addSum)
  );

  // ----------------------------------------------------------------
  // address decode and write qualification
  // ----------------------------------------------------------------
  // lock blocks software only; the engine may still update the literal
  assign locked = enable_reg & run_reg;
  assign selLit = (busAddr == SLR_LIT_OFS);
  assign selAdj = (busAddr == SLR_ADJ_OFS);
  assign selCtrl = (busAddr == SLR_CTRL_OFS);
  assign selStat = (busAddr == SLR_STAT_OFS);
  assign swWrLit = busWr & selLit & ~locked;
  assign swWrAdj = busWr & selAdj & ~locked;
  assign swWrCtrl = busWr & selCtrl;
  assign hwAddLit = stepCmd.addStep & (stepCmd.target == SLR_TGT_LITERAL);
  assign hwAddOut = stepCmd.addStep & (stepCmd.target != SLR_TGT_LITERAL);

  // ----------------------------------------------------------------
  // next values of literal and adjust
  // ----------------------------------------------------------------
  // engine add wins over a software write in the same cycle
  always_comb begin
    stepLiteralValue_next = stepLiteralValue_reg;
    if (hwAddLit) begin
      stepLiteralValue_next = addSum;
    end else if (swWrLit) begin
      stepLiteralValue_next = hwdata[DW-1:0];
    end
  end

  always_comb begin
    stepAdjustValue_next = stepAdjustValue_reg;
    if (swWrAdj) begin
      stepAdjustValue_next = hwdata[DW-1:0];
    end
  end

  // literal register, zero at power-on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stepLiteralValue_reg <= SLR_LIT_RST;
    end else begin
      stepLiteralValue_reg <= stepLiteralValue_next;
    end
  end

  // adjust register, zero at power-on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stepAdjustValue_reg <= SLR_ADJ_RST;
    end else begin
      stepAdjustValue_reg <= stepAdjustValue_next;
    end
  end

  // ----------------------------------------------------------------
  // sequencer control bits, always writable
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (swWrCtrl) begin
      enable_reg <= hwdata[SLR_CTRL_EN_BIT];
      run_reg <= hwdata[SLR_CTRL_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // channel select load from the literal
  // ----------------------------------------------------------------
  // copies the value held before any same-cycle add lands
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chanSel_reg <= SLR_CHAN_RST;
      chanLoad_reg <= 1'b0;
    end else begin
      chanLoad_reg <= stepCmd.ctrlLiteral;
      if (stepCmd.ctrlLiteral) begin
        chanSel_reg <= stepLiteralValue_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // limit write-back for outside targets
  // ----------------------------------------------------------------
  always_comb begin
    limWrite_next.timerWr = hwAddOut & (stepCmd.target == SLR_TGT_TIMER);
    limWrite_next.counterWr = hwAddOut & (stepCmd.target == SLR_TGT_COUNTER);
    limWrite_next.delayWr = hwAddOut & (stepCmd.target == SLR_TGT_DELAY);
    limWrite_next.data = hwAddOut ? addSum : limWrite_reg.data;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      limWrite_reg <= '0;
      lastTarget_reg <= SLR_TGT_TIMER;
    end else begin
      limWrite_reg <= limWrite_next;
      if (stepCmd.addStep) begin
        lastTarget_reg <= stepCmd.target;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux, unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    readMux = '0;
    if (selLit) begin
      readMux[DW-1:0] = stepLiteralValue_reg;
    end else if (selAdj) begin
      readMux[DW-1:0] = stepAdjustValue_reg;
    end else if (selCtrl) begin
      readMux[SLR_CTRL_EN_BIT] = enable_reg;
      readMux[SLR_CTRL_RUN_BIT] = run_reg;
    end else if (selStat) begin
      readMux[SLR_STAT_LOCK_BIT] = locked;
      readMux[SLR_STAT_TGT_LSB +: 2] = lastTarget_reg;
    end
  end

  // hsize is unused: only whole-word transfers are supported
  assign hrdata = busRd ? readMux : '0;
  assign limWrite = limWrite_reg;
  assign converterChannelSelect = chanSel_reg;
  assign chanLoad = chanLoad_reg;
  assign sequencerEnable = enable_reg;
  assign sequencerRun = run_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  chan_copy_a: assert property (stepCmd.ctrlLiteral |=>
      chanLoad && converterChannelSelect == $past(stepLiteralValue_reg))
    else $error("channel select did not take the literal");

  lit_lock_a: assert property ((locked && busWr && selLit && !hwAddLit) |=>
      $stable(stepLiteralValue_reg))
    else $error("literal changed by a write while locked");

  adj_lock_a: assert property ((locked && busWr && selAdj) |=>
      $stable(stepAdjustValue_reg))
    else $error("adjust changed by a write while locked");

  add_lit_a: assert property (hwAddLit |=>
      stepLiteralValue_reg == DW'($past(stepLiteralValue_reg) + $past(stepAdjustValue_reg)))
    else $error("literal add result wrong");

  add_timer_a: assert property ((stepCmd.addStep && stepCmd.target == SLR_TGT_TIMER) |=>
      limWrite.timerWr && !limWrite.counterWr && !limWrite.delayWr
      && limWrite.data == DW'($past(limits.timerLimit) + $past(stepAdjustValue_reg)))
    else $error("timer limit write-back wrong");

  add_delay_a: assert property ((stepCmd.addStep && stepCmd.target == SLR_TGT_DELAY) |=>
      limWrite.delayWr
      && limWrite.data == DW'($past(limits.delayLimit) + $past(stepAdjustValue_reg)))
    else $error("delay limit write-back wrong");

  lit_write_a: assert property ((!locked && busWr && selLit && !hwAddLit) |=>
      stepLiteralValue_reg == $past(hwdata[DW-1:0]))
    else $error("literal write not stored");

  adj_write_a: assert property ((!locked && busWr && selAdj) |=>
      stepAdjustValue_reg == $past(hwdata[DW-1:0]))
    else $error("adjust write not stored");

  adj_read_a: assert property ((busRd && selAdj) |->
      hrdata == {16'h0000, stepAdjustValue_reg})
    else $error("adjust readback wrong");

  no_strobe_a: assert property (!stepCmd.addStep |=>
      !limWrite.timerWr && !limWrite.counterWr && !limWrite.delayWr)
    else $error("spurious limit write strobe");

  // counter write-back, hold and readback checks: nothing moves unless its own strobe is up
  add_count_a: assert property ((stepCmd.addStep && stepCmd.target == SLR_TGT_COUNTER) |=>
      limWrite.counterWr && !limWrite.timerWr && !limWrite.delayWr
      && limWrite.data == DW'($past(limits.counterLimit) + $past(stepAdjustValue_reg)))
    else $error("counter limit write-back wrong");

  lit_read_a: assert property ((busRd && selLit) |->
      hrdata == {16'h0000, stepLiteralValue_reg})
    else $error("literal readback wrong");

  chan_hold_a: assert property (!stepCmd.ctrlLiteral |=>
      !chanLoad && $stable(converterChannelSelect))
    else $error("channel select moved without a command");

  adj_hold_a: assert property (!swWrAdj |=>
      $stable(stepAdjustValue_reg))
    else $error("adjust changed without a software write");

  lit_hold_a: assert property (!(swWrLit || hwAddLit) |=>
      $stable(stepLiteralValue_reg))
    else $error("literal changed without a write or add");

  lock_flag_a: assert property ((busRd && selStat) |->
      hrdata[SLR_STAT_LOCK_BIT] == (sequencerEnable && sequencerRun))
    else $error("lock status bit wrong");

  sum_hold_a: assert property (!hwAddOut |=>
      $stable(limWrite.data))
    else $error("limit write data moved without an add");

  lock_write_c: cover property (locked && busWr && selLit);
  add_lit_c: cover property (hwAddLit && stepCmd.ctrlLiteral);
  add_counter_c: cover property (stepCmd.addStep && stepCmd.target == SLR_TGT_COUNTER);
  run_start_c: cover property (!locked ##1 locked);

endmodule

// ==== bench/slr_tb.sv ====
// self-checking bench of the literal and adjust register bank
`timescale 1ns/1ps
module tb import slr_pkg::*;
;
  logic ref_clk, rstn, hsel, hwrite;
  logic [31:0] haddr, hwdata, seed;
  logic [1:0] htrans, ctrlM, tgtM;
  logic [2:0] hsize;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, chanLoad, seqEn, seqRun;
  wire logic [SLR_DW-1:0] chanSel;
  slr_cmd_t stepCmd;
  slr_limits_t limits;
  slr_lim_wr_t limWrite;
  logic [15:0] litM, adjM;
  logic [31:0] expQ[$];
  logic rdPh;
  int errCount, compares;

  slr_regs dut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .stepCmd(stepCmd), .limits(limits),
    .limWrite(limWrite), .converterChannelSelect(chanSel), .chanLoad(chanLoad),
    .sequencerEnable(seqEn), .sequencerRun(seqRun));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a result with no note pending is itself a fault
  task automatic take(input string what, input logic [31:0] seen);
    if (expQ.size() == 0) begin
      errCount++;
      $display("BAD %s expected nothing seen %h", what, seen);
    end else chk(what, seen, expQ.pop_front());
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic roll();
    seed = lfsr(seed);
  endtask

  // ----------------------------------------------------------------
  // bus master: hold each phase until hready is sampled high
  // ----------------------------------------------------------------
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 50) begin
      errCount++;
      wrapUp();
    end
  endtask

  task automatic busXfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~d;
    waitRdy();
  endtask

  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    logic lock;
    lock = (ctrlM == 2'h3);
    if (a == SLR_LIT_OFS && !lock) litM = d[15:0];
    if (a == SLR_ADJ_OFS && !lock) adjM = d[15:0];
    if (a == SLR_CTRL_OFS) ctrlM = d[1:0];
    busXfer(a, 1'h1, d);
  endtask

  task automatic regRd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    busXfer(a, 1'h0, 32'h00000000);
  endtask

  // one engine command, fresh random limits sampled with it
  task automatic step(input logic lit, input logic add, input logic [1:0] t);
    logic [15:0] op;
    roll();
    limits <= {seed[15:0], seed[31:16], seed[15:0] ^ 16'hA5A5};
    op = (t == 2'h0) ? seed[15:0] : (t == 2'h1) ? seed[31:16] :
      (t == 2'h2) ? (seed[15:0] ^ 16'hA5A5) : litM;
    if (lit) expQ.push_back({16'h0000, litM});
    if (add && t != 2'h3) expQ.push_back({13'h0000, t == 2'h0, t == 2'h1, t == 2'h2, op + adjM});
    if (add && t == 2'h3) litM = litM + adjM;
    if (add) tgtM = t;
    stepCmd <= {lit, add, t};
    @(posedge ref_clk);
    stepCmd <= '0;
    @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // monitor: every result that appears takes the oldest note
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rdPh <= 1'h0;
    else rdPh <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  // negedge sampling keeps clear of the launching edge
  always @(negedge ref_clk) begin
    if (rdPh) take("read data", hrdata);
    if (rdPh) chk("bus response", {31'h00000000, hresp}, 32'h00000000);
    if (chanLoad) take("channel select", {16'h0000, chanSel});
    if (limWrite.timerWr || limWrite.counterWr || limWrite.delayWr) begin
      take("limit write", {13'h0000, limWrite});
    end
  end

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    rstn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    stepCmd = '0;
    limits = '0;
    seed = 32'hFF2EA64D;
    {litM, adjM, ctrlM, tgtM} = '0;
    errCount = 0;
    compares = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'h1;
    @(posedge ref_clk);
    // power-on values of every register
    regRd(SLR_LIT_OFS, 32'h00000000);
    regRd(SLR_ADJ_OFS, 32'h00000000);
    regRd(SLR_CTRL_OFS, 32'h00000000);
    regRd(SLR_STAT_OFS, 32'h00000000);
    // all bits writable, upper half dropped, every add target
    for (int i = 0; i < 4; i++) begin
      roll();
      d = (i == 0) ? 32'hFFFFFFFF : seed;
      regWr(SLR_LIT_OFS, d);
      regWr(SLR_ADJ_OFS, ~d);
      regRd(SLR_LIT_OFS, {16'h0000, litM});
      regRd(SLR_ADJ_OFS, {16'h0000, adjM});
      step(1'h1, 1'h0, 2'h0);
      for (int t = 0; t < 4; t++) step(1'h0, 1'h1, t[1:0]);
      regRd(SLR_LIT_OFS, {16'h0000, litM});
    end
    // locked: software writes ignored, engine still works
    regWr(SLR_CTRL_OFS, 32'h00000003);
    // control bits settle after the storing edge, so look mid-cycle
    @(negedge ref_clk);
    chk("control outputs", {30'h00000000, seqRun, seqEn}, 32'h00000003);
    @(posedge ref_clk);
    regRd(SLR_STAT_OFS, {29'h00000000, tgtM, 1'h1});
    regWr(SLR_LIT_OFS, {16'h0000, ~litM});
    regWr(SLR_ADJ_OFS, {16'h0000, ~adjM});
    regRd(SLR_LIT_OFS, {16'h0000, litM});
    regRd(SLR_ADJ_OFS, {16'h0000, adjM});
    step(1'h1, 1'h1, 2'h3);
    regRd(SLR_LIT_OFS, {16'h0000, litM});
    // only one of the two controls set leaves writes open
    for (int c = 1; c < 3; c++) begin
      regWr(SLR_CTRL_OFS, c);
      @(negedge ref_clk);
      chk("control outputs", {30'h00000000, seqRun, seqEn}, c);
      @(posedge ref_clk);
      regWr(SLR_LIT_OFS, 32'h0000C3C0 + c);
      regWr(SLR_ADJ_OFS, 32'h00003C30 + c);
      regRd(SLR_LIT_OFS, {16'h0000, litM});
      regRd(SLR_ADJ_OFS, {16'h0000, adjM});
    end
    // unmapped place reads zero and leaves the literal alone
    regWr(8'h10, 32'hFFFFFFFF);
    regRd(8'h10, 32'h00000000);
    regRd(SLR_LIT_OFS, {16'h0000, litM});
    // second reset in mid-run clears both registers again
    rstn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    {litM, adjM, ctrlM, tgtM} = '0;
    @(posedge ref_clk);
    regRd(SLR_LIT_OFS, 32'h00000000);
    regRd(SLR_ADJ_OFS, 32'h00000000);
    regRd(SLR_CTRL_OFS, 32'h00000000);
    regRd(SLR_STAT_OFS, 32'h00000000);
    repeat (2) @(posedge ref_clk);
    chk("notes left over", 32'(expQ.size()), 32'h00000000);
    wrapUp();
  end
endmodule
